// File: acrd_defines.svh
/*
  Constants of the command register decoder: field positions, reset values, times.
  Assumes inclusion by its bare name from every design file that needs a number.
*/
// Contract
// - Leading bits classify each byte: conversion, setup, averaging or reset command.
// - Conversion byte: channel bits 6..3, sweep mode bits 2..1, temperature bit 0.
// - Channel field is an unsigned index N selecting analog inputs 0 to 15.
// - Sweep 00 converts 0 up to N; sweep 01 converts N up to top.
// - Sweep 10 converts channel N repeatedly, count from averaging repeat bits.
// - Sweep 11 converts channel N exactly once.
// - Temperature bit set gives one temperature result, first in the sweep.
// - Timing 1x starts on conversion byte; timing 0x on conversion-start low pulse.
// - Skip channels reassigned as conversion-start or negative reference input.
// - Top differential pair with a reassigned member is ignored entirely.
// - Setup byte: timing bits 5..4, voltage source bits 3..2, pair select 1..0.
// - Pair select 10/11 stores the next byte into unipolar/bipolar pair register.
// - Pair select 00/01 leaves pair registers alone; next byte is a command.
// - Pair enabled in both pair registers is treated as unipolar.
// - Unipolar differential results straight binary, bipolar results two's complement.
// - Averaging register sets up to 32 samples per result and repeat count.
// - Averaging applies in any sweep mode only while averaging enable bit 4 set; the code also turns it off in timing mode 11.
// - Sweep time is sample time times samples times results, plus temp and wake.
// - Pair bit 7 covers inputs 0 and 1, down to bit 0 for 14 and 15.
// - Registers reset to zero except setup, which resets to timing mode 10.
// - Serial bits latched on serial clock rising edge, chip select low, MSB first.
`ifndef ACRD_DEFINES_SVH
`define ACRD_DEFINES_SVH

`define ACRD_CONV_BIT      7
`define ACRD_CHAN_HI       6
`define ACRD_CHAN_LO       3
`define ACRD_SWEEP_HI      2
`define ACRD_SWEEP_LO      1
`define ACRD_TEMP_BIT      0
`define ACRD_SETUP_BIT     6
`define ACRD_TIMING_HI     5
`define ACRD_TIMING_LO     4
`define ACRD_VSRC_HI       3
`define ACRD_VSRC_LO       2
`define ACRD_PSEL_HI       1
`define ACRD_PSEL_LO       0
`define ACRD_AVG_BIT       5
`define ACRD_AVG_EN_BIT    4
`define ACRD_SCNT_HI       3
`define ACRD_SCNT_LO       2
`define ACRD_RCNT_HI       1
`define ACRD_RCNT_LO       0
`define ACRD_RESET_BIT     4
`define ACRD_FIFO_CLR_BIT  3

`define ACRD_CONV_RST      7'h00
`define ACRD_SETUP_RST     6'h20
`define ACRD_AVG_RST       5'h00
`define ACRD_PAIR_RST      8'h00

`define ACRD_PSEL_UNI      2'h2
`define ACRD_PSEL_BIP      2'h3
`define ACRD_VSRC_EXT_DIFF 2'h3
`define ACRD_VSRC_WAKE     2'h0
`define ACRD_BITS_PER_BYTE 3'h7

`define ACRD_CLK_PERIOD_NS 100
`define ACRD_T_SAMPLE_NS   2000
`define ACRD_T_TEMP_NS     20000
`define ACRD_T_WAKE_NS     65000
`define ACRD_CYC(ns)       (((ns) + `ACRD_CLK_PERIOD_NS - 1) / `ACRD_CLK_PERIOD_NS)
`define ACRD_SAMPLE_CYC    `ACRD_CYC(`ACRD_T_SAMPLE_NS)
`define ACRD_TEMP_CYC      `ACRD_CYC(`ACRD_T_TEMP_NS)
`define ACRD_WAKE_CYC      `ACRD_CYC(`ACRD_T_WAKE_NS)
`define ACRD_SAMPLE_SHIFT  2
`define ACRD_REPEAT_STEP   4

`endif

// File: acrd_pkg.sv
/*
  Types of the command register decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acrd_pkg;

  typedef enum logic [1:0] {
    ACRD_ST_IDLE = 2'b00,
    ACRD_ST_TEMP = 2'b01,
    ACRD_ST_SCAN = 2'b10,
    ACRD_ST_WAIT = 2'b11
  } acrd_state_t;

  typedef enum logic [1:0] {
    ACRD_SW_LOW_UP  = 2'b00,
    ACRD_SW_N_UP    = 2'b01,
    ACRD_SW_REPEAT  = 2'b10,
    ACRD_SW_SINGLE  = 2'b11
  } acrd_sweep_t;

endpackage : acrd_pkg

// File: acrd_link_rx.sv
/*
  Serial byte receiver on the link clock.
  Assumes the host is an SPI master; serial clock stands still outside frames.
*/
`timescale 1ns/1ps
`include "acrd_defines.svh"

module acrd_link_rx (
  input  wire logic       i_sclk,
  input  wire logic       i_reset,
  input  wire logic       i_cs_n,
  input  wire logic       i_mosi,
  output logic [7:0]      o_byte,
  output logic            o_byte_toggle
);

  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic       frame_rst;

  // chip select high ends the frame even though the link clock has stopped
  assign frame_rst = i_cs_n | i_reset;

  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      shift_q <= 7'h00;
    end else if (!i_cs_n) begin
      shift_q <= {shift_q[5:0], i_mosi};
    end
  end

  // byte and toggle change on the same edge; byte then holds for a whole byte time
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      o_byte        <= 8'h00;
      o_byte_toggle <= 1'b0;
    end else if (!i_cs_n && bit_cnt_q == `ACRD_BITS_PER_BYTE) begin
      o_byte        <= {shift_q, i_mosi};
      o_byte_toggle <= ~o_byte_toggle;
    end
  end

endmodule : acrd_link_rx

// File: acrd_top.sv
/*
  Command register decoder and sweep sequencer of a multi-channel converter.
  Assumes a converter core on i_clk that acknowledges each request with
  i_conv_done, and an SPI master on the link pins.
*/
`timescale 1ns/1ps
`include "acrd_defines.svh"

module acrd_top #(
  parameter int NCH = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic        i_conv_start_n,
  input  wire logic        i_conv_done,
  output logic             o_conv_req,
  output logic [3:0]       o_conv_channel,
  output logic             o_conv_temp,
  output logic             o_conv_diff,
  output logic             o_conv_bipolar,
  output logic [5:0]       o_samples_per_result,
  output logic             o_busy,
  output logic [1:0]       o_timing_mode,
  output logic [1:0]       o_voltage_source,
  output logic             o_fifo_clear,
  output logic [23:0]      o_sweep_cycles
);

  localparam logic [3:0] TOP_CH  = 4'(NCH - 1);
  localparam logic [3:0] NREF_CH = 4'(NCH - 2);

  //////////////////////////////////////////////////////////////////////////////
  // link crossing

  logic [7:0] link_byte;
  logic       link_toggle;

  acrd_link_rx u_rx (
    .i_sclk        (i_sclk),
    .i_reset       (i_reset),
    .i_cs_n        (i_cs_n),
    .i_mosi        (i_mosi),
    .o_byte        (link_byte),
    .o_byte_toggle (link_toggle)
  );

  logic [2:0] tog_sync_q;
  logic [2:0] cs_sync_q;
  logic [2:0] cst_sync_q;
  logic       byte_evt;
  logic       frame_end;
  logic       start_pulse;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tog_sync_q <= 3'h0;
      cs_sync_q  <= 3'h7;
      cst_sync_q <= 3'h7;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], link_toggle};
      cs_sync_q  <= {cs_sync_q[1:0], i_cs_n};
      cst_sync_q <= {cst_sync_q[1:0], i_conv_start_n};
    end
  end

  // only stages two and three are looked at
  assign byte_evt    = tog_sync_q[2] ^ tog_sync_q[1];
  assign frame_end   = cs_sync_q[1] & ~cs_sync_q[2];
  assign start_pulse = cst_sync_q[2] & ~cst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  logic [6:0] conv_q;
  logic [5:0] setup_q;
  logic [4:0] avg_q;
  logic [7:0] uni_q;
  logic [7:0] bip_q;
  logic       pair_wait_q;
  logic       conv_wr;
  logic       reset_all;

  assign conv_wr   = byte_evt && !pair_wait_q && link_byte[`ACRD_CONV_BIT];
  assign reset_all = byte_evt && !pair_wait_q && link_byte[7:4] == 4'h1
                     && !link_byte[`ACRD_FIFO_CLR_BIT];

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      conv_q <= `ACRD_CONV_RST;
    end else if (conv_wr) begin
      conv_q <= link_byte[`ACRD_CHAN_HI:`ACRD_TEMP_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      setup_q <= `ACRD_SETUP_RST;
    end else if (byte_evt && !pair_wait_q && link_byte[7:6] == 2'h1) begin
      setup_q <= link_byte[`ACRD_TIMING_HI:`ACRD_PSEL_LO];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      avg_q <= `ACRD_AVG_RST;
    end else if (byte_evt && !pair_wait_q && link_byte[7:5] == 3'h1) begin
      avg_q <= link_byte[`ACRD_AVG_EN_BIT:`ACRD_RCNT_LO];
    end
  end

  // a setup byte arriving with the frame end still arms the data byte
  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      pair_wait_q <= 1'b0;
    end else if (byte_evt && !pair_wait_q && link_byte[7:6] == 2'h1) begin
      pair_wait_q <= link_byte[`ACRD_PSEL_HI];
    end else if (byte_evt || frame_end) begin
      pair_wait_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      uni_q <= `ACRD_PAIR_RST;
      bip_q <= `ACRD_PAIR_RST;
    end else if (byte_evt && pair_wait_q) begin
      if (setup_q[`ACRD_PSEL_HI:`ACRD_PSEL_LO] == `ACRD_PSEL_UNI) begin
        uni_q <= link_byte;
      end else if (setup_q[`ACRD_PSEL_HI:`ACRD_PSEL_LO] == `ACRD_PSEL_BIP) begin
        bip_q <= link_byte;
      end
    end
  end

  // upper nibble zero is not a command and falls through every decode above
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fifo_clear <= 1'b0;
    end else begin
      o_fifo_clear <= byte_evt && !pair_wait_q && link_byte[7:4] == 4'h1
                      && link_byte[`ACRD_FIFO_CLR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel helpers

  function automatic logic reassigned(input logic [3:0] ch, input logic [5:0] st);
    logic cst_pin;
    logic nref_pin;
    cst_pin  = !st[`ACRD_TIMING_HI] && ch == TOP_CH;
    nref_pin = st[`ACRD_VSRC_HI:`ACRD_VSRC_LO] != `ACRD_VSRC_EXT_DIFF && ch == NREF_CH;
    return cst_pin | nref_pin;
  endfunction : reassigned

  function automatic logic [2:0] pair_bit(input logic [3:0] ch);
    return 3'h7 - ch[3:1];
  endfunction : pair_bit

  function automatic logic [5:0] samples(input logic [4:0] av, input logic [1:0] tm);
    logic [5:0] n;
    n = 6'h01;
    if (av[`ACRD_AVG_EN_BIT] && tm != 2'h3) begin
      n = 6'(6'h01 << (3'(av[`ACRD_SCNT_HI:`ACRD_SCNT_LO]) + 3'(`ACRD_SAMPLE_SHIFT)));
    end
    return n;
  endfunction : samples

  logic       is_diff;
  logic       is_bip;
  logic       skip_ch;
  logic [3:0] chan_q;

  always_comb begin
    is_diff = uni_q[pair_bit(chan_q)] | bip_q[pair_bit(chan_q)];
    is_bip  = bip_q[pair_bit(chan_q)] & ~uni_q[pair_bit(chan_q)];
    if (is_diff) begin
      skip_ch = chan_q[0] || reassigned({chan_q[3:1], 1'b0}, setup_q)
                || reassigned({chan_q[3:1], 1'b1}, setup_q);
    end else begin
      skip_ch = reassigned(chan_q, setup_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sweep sequencer

  acrd_pkg::acrd_state_t state_q;
  acrd_pkg::acrd_sweep_t sweep;
  logic [3:0]            last_q;
  logic [4:0]            reps_q;
  logic                  start_sweep;
  logic                  at_end;
  logic                  timed;

  assign sweep  = acrd_pkg::acrd_sweep_t'(conv_q[`ACRD_SWEEP_HI:`ACRD_SWEEP_LO]);
  assign timed  = !setup_q[`ACRD_TIMING_LO];
  assign at_end = (sweep == acrd_pkg::ACRD_SW_REPEAT) ? (reps_q == 5'h01)
                                                      : (chan_q == last_q);
  // a conversion byte in timing 1x starts on the cycle after it is stored
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      start_sweep <= 1'b0;
    end else begin
      start_sweep <= (conv_wr && setup_q[`ACRD_TIMING_HI])
                     || (start_pulse && !setup_q[`ACRD_TIMING_HI]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      state_q <= acrd_pkg::ACRD_ST_IDLE;
    end else begin
      case (state_q)
        acrd_pkg::ACRD_ST_IDLE: begin
          if (start_sweep) begin
            state_q <= conv_q[`ACRD_TEMP_BIT] ? acrd_pkg::ACRD_ST_TEMP
                                              : acrd_pkg::ACRD_ST_SCAN;
          end
        end
        acrd_pkg::ACRD_ST_TEMP: begin
          if (i_conv_done) begin
            state_q <= acrd_pkg::ACRD_ST_SCAN;
          end
        end
        acrd_pkg::ACRD_ST_SCAN: begin
          if (!skip_ch) begin
            state_q <= acrd_pkg::ACRD_ST_WAIT;
          end else if (at_end || sweep == acrd_pkg::ACRD_SW_REPEAT) begin
            state_q <= acrd_pkg::ACRD_ST_IDLE;
          end
        end
        acrd_pkg::ACRD_ST_WAIT: begin
          if (i_conv_done) begin
            state_q <= at_end ? acrd_pkg::ACRD_ST_IDLE : acrd_pkg::ACRD_ST_SCAN;
          end
        end
        default: begin
          state_q <= acrd_pkg::ACRD_ST_IDLE;
        end
      endcase
    end
  end

  // first and last channel and repeat count are fixed at sweep start; a later conversion byte still changes the sweep mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      chan_q <= 4'h0;
      last_q <= 4'h0;
      reps_q <= 5'h00;
    end else if (state_q == acrd_pkg::ACRD_ST_IDLE && start_sweep) begin
      chan_q <= (sweep == acrd_pkg::ACRD_SW_LOW_UP) ? 4'h0
                                                    : conv_q[6:3];
      last_q <= (sweep == acrd_pkg::ACRD_SW_N_UP) ? TOP_CH : conv_q[6:3];
      reps_q <= (sweep == acrd_pkg::ACRD_SW_REPEAT)
                ? 5'((avg_q[`ACRD_RCNT_HI:`ACRD_RCNT_LO] + 3'h1) * `ACRD_REPEAT_STEP)
                : 5'h01;
    end else if ((state_q == acrd_pkg::ACRD_ST_SCAN && skip_ch && !at_end)
                 || (state_q == acrd_pkg::ACRD_ST_WAIT && i_conv_done && !at_end)) begin
      if (sweep == acrd_pkg::ACRD_SW_REPEAT) begin
        reps_q <= reps_q - 5'h01;
      end else begin
        chan_q <= chan_q + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // requests to the converter core

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      o_conv_req     <= 1'b0;
      o_conv_channel <= 4'h0;
      o_conv_temp    <= 1'b0;
      o_conv_diff    <= 1'b0;
      o_conv_bipolar <= 1'b0;
    end else if (state_q == acrd_pkg::ACRD_ST_IDLE && start_sweep
                 && conv_q[`ACRD_TEMP_BIT]) begin
      o_conv_req  <= 1'b1;
      o_conv_temp <= 1'b1;
      o_conv_diff <= 1'b0;
    end else if (state_q == acrd_pkg::ACRD_ST_SCAN && !skip_ch) begin
      o_conv_req     <= 1'b1;
      o_conv_temp    <= 1'b0;
      o_conv_channel <= chan_q;
      o_conv_diff    <= is_diff;
      o_conv_bipolar <= is_diff & is_bip;
    end else if (i_conv_done) begin
      o_conv_req <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_busy               <= 1'b0;
      o_timing_mode        <= 2'h2;
      o_voltage_source     <= 2'h0;
      o_samples_per_result <= 6'h01;
    end else begin
      o_busy               <= state_q != acrd_pkg::ACRD_ST_IDLE;
      o_timing_mode        <= setup_q[`ACRD_TIMING_HI:`ACRD_TIMING_LO];
      o_voltage_source     <= setup_q[`ACRD_VSRC_HI:`ACRD_VSRC_LO];
      o_samples_per_result <= samples(avg_q, setup_q[`ACRD_TIMING_HI:`ACRD_TIMING_LO]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sweep time, accumulated as the sweep runs so skipped channels cost nothing

  logic [23:0] acc_q;
  logic [23:0] sample_term;

  assign sample_term = 24'(`ACRD_SAMPLE_CYC)
                       * 24'(samples(avg_q, setup_q[`ACRD_TIMING_HI:`ACRD_TIMING_LO]));

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      acc_q <= 24'h000000;
    end else if (state_q == acrd_pkg::ACRD_ST_IDLE && start_sweep) begin
      acc_q <= (conv_q[`ACRD_TEMP_BIT] ? 24'(`ACRD_TEMP_CYC) : 24'h000000)
               + ((setup_q[`ACRD_VSRC_HI:`ACRD_VSRC_LO] == `ACRD_VSRC_WAKE)
                  ? 24'(`ACRD_WAKE_CYC) : 24'h000000);
    end else if (state_q == acrd_pkg::ACRD_ST_SCAN && !skip_ch) begin
      acc_q <= acc_q + sample_term;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || reset_all) begin
      o_sweep_cycles <= 24'h000000;
    end else if (state_q != acrd_pkg::ACRD_ST_IDLE && o_busy && timed) begin
      o_sweep_cycles <= acc_q;
    end else if (!timed) begin
      o_sweep_cycles <= 24'h000000;
    end
  end

endmodule : acrd_top

// File: acrd_properties.sv
/*
  Checker of the decoder's requests and register outputs.
  Assumes binding into acrd_top, NCH handed on by the bind.
*/
`timescale 1ns/1ps

module acrd_properties #(
  parameter int NCH = 16
) (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_conv_start_n,
  input wire logic       i_conv_done,
  input wire logic       o_conv_req,
  input wire logic [3:0] o_conv_channel,
  input wire logic       o_conv_temp,
  input wire logic       o_conv_diff,
  input wire logic       o_conv_bipolar,
  input wire logic [5:0] o_samples_per_result,
  input wire logic       o_busy,
  input wire logic [1:0] o_timing_mode,
  input wire logic [1:0] o_voltage_source,
  input wire logic       o_fifo_clear
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic chan_seen_q;
  // temperature leads, so a channel result bars a later temperature one
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_busy) chan_seen_q <= 1'b0;
    else if (o_conv_req && !o_conv_temp) chan_seen_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_pending; o_conv_req && !i_conv_done; endsequence
  sequence s_answered; o_conv_req && i_conv_done; endsequence

  property p_req_holds;
    s_pending |=> o_conv_req && $stable(o_conv_channel) && $stable(o_conv_diff);
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("request changed early");
  property p_req_ends; s_answered |=> !o_conv_req; endproperty
  a_req_ends: assert property (p_req_ends) else $error("request outlived done");
  property p_reset_vals;
    $fell(i_reset) |-> o_timing_mode == 2'h2 && o_voltage_source == 2'h0 && !o_conv_req
      && !o_busy && o_samples_per_result == 6'h01;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
  property p_single_uni; o_conv_req && !o_conv_diff && !o_conv_temp |-> !o_conv_bipolar; endproperty
  a_single_uni: assert property (p_single_uni) else $error("single input bipolar");
  property p_pair_even; o_conv_req && o_conv_diff |-> !o_conv_channel[0]; endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair on odd input");
  property p_pin_skip;
    o_conv_req && !o_conv_temp && !o_timing_mode[1] |-> o_conv_channel != 4'(NCH - 1);
  endproperty
  a_pin_skip: assert property (p_pin_skip) else $error("start pin input converted");
  property p_ref_skip;
    o_conv_req && !o_conv_temp && o_voltage_source != 2'h3 |-> o_conv_channel != 4'(NCH - 2);
  endproperty
  a_ref_skip: assert property (p_ref_skip) else $error("reference input converted");
  property p_temp_first; o_conv_req && o_conv_temp |-> !chan_seen_q; endproperty
  a_temp_first: assert property (p_temp_first) else $error("temperature not first");
  property p_ext_no_avg;
    o_timing_mode == 2'h3 && $stable(o_timing_mode) |-> o_samples_per_result == 6'h01;
  endproperty
  a_ext_no_avg: assert property (p_ext_no_avg) else $error("averaging in mode 11");
  property p_pin_start;
    $fell(i_conv_start_n) && !o_timing_mode[1] && !o_busy |-> ##[2:10] o_busy;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin did not start");
  property p_busy_req; $rose(o_conv_req) |=> o_busy; endproperty
  a_busy_req: assert property (p_busy_req) else $error("request while idle");
  property p_fifo_pulse; o_fifo_clear |=> !o_fifo_clear; endproperty
  a_fifo_pulse: assert property (p_fifo_pulse) else $error("clear pulse too long");
endmodule : acrd_properties

bind acrd_top acrd_properties #(.NCH(NCH)) u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_conv_start_n(i_conv_start_n),
  .i_conv_done(i_conv_done), .o_conv_req(o_conv_req), .o_conv_channel(o_conv_channel),
  .o_conv_temp(o_conv_temp), .o_conv_diff(o_conv_diff), .o_conv_bipolar(o_conv_bipolar),
  .o_samples_per_result(o_samples_per_result), .o_busy(o_busy),
  .o_timing_mode(o_timing_mode), .o_voltage_source(o_voltage_source),
  .o_fifo_clear(o_fifo_clear)
);

// File: acrd_host_model.sv
/*
  Serial master model writing command bytes, 6 ns link clock.
  Assumes the decoder samples on the link clock rise, MSB first.
*/
`timescale 1ns/1ps

module acrd_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
  end

  // 600 ns gap: the decoder loses bytes closer than 300 ns
  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_mosi = b[i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    o_mosi = ~b[0];
    #600;
  endtask : shift_byte

  task automatic send1(input logic [7:0] b);
    o_cs_n = 1'b0;
    #20 shift_byte(b);
    o_cs_n = 1'b1;
    #600;
  endtask : send1

  // select held low over all 16 link clocks
  task automatic send2(input logic [15:0] w);
    o_cs_n = 1'b0;
    #20 shift_byte(w[15:8]);
    shift_byte(w[7:0]);
    o_cs_n = 1'b1;
    #600;
  endtask : send2
endmodule : acrd_host_model

// File: tb_adc_command_register_decoder.sv
/*
  Self-checking bench of the command decoder with a converter stub.
  Assumes acrd_top, the host model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, s); end end

module tb_adc_command_register_decoder;
  typedef logic [6:0] acrd_exp_t[$];
  logic        i_clk, i_reset, i_sclk, i_cs_n, i_mosi, i_conv_start_n, i_conv_done;
  logic        o_conv_req, o_conv_temp, o_conv_diff, o_conv_bipolar, o_busy, o_fifo_clear;
  logic [3:0]  o_conv_channel;
  logic [5:0]  o_samples_per_result;
  logic [1:0]  o_timing_mode, o_voltage_source;
  logic [23:0] o_sweep_cycles;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  acrd_top dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
    .i_conv_start_n(i_conv_start_n), .i_conv_done(i_conv_done), .o_conv_req(o_conv_req),
    .o_conv_channel(o_conv_channel), .o_conv_temp(o_conv_temp), .o_conv_diff(o_conv_diff),
    .o_conv_bipolar(o_conv_bipolar), .o_samples_per_result(o_samples_per_result),
    .o_busy(o_busy), .o_timing_mode(o_timing_mode), .o_voltage_source(o_voltage_source),
    .o_fifo_clear(o_fifo_clear), .o_sweep_cycles(o_sweep_cycles));
  acrd_host_model host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask : tick

  // acts as converter: answers each request, then waits for the sweep to end
  task automatic expect_sweep(input acrd_exp_t exp);
    int w;
    foreach (exp[k]) begin
      w = 0;
      while (o_conv_req !== 1'b1 && w < 1000) begin tick(1); w++; end
      `CHK("request seen", 1'b1, o_conv_req)
      `CHK("temp flag", exp[k][6], o_conv_temp)
      if (!exp[k][6]) `CHK("request", exp[k], {o_conv_temp, o_conv_diff, o_conv_bipolar, o_conv_channel})
      tick(1);
      `CHK("request stands", 1'b1, o_conv_req)
      i_conv_done = 1'b1;
      tick(1);
      i_conv_done = 1'b0;
    end
    w = 0;
    while (o_busy !== 1'b0 && w < 50) begin tick(1); w++; end
    `CHK("sweep end", 2'h0, {o_busy, o_conv_req})
  endtask : expect_sweep

  task automatic t_reset_values;
    `CHK("timing mode", 2'h2, o_timing_mode)
    `CHK("source", 2'h0, o_voltage_source)
    `CHK("samples", 6'h01, o_samples_per_result)
    `CHK("idle", 2'h0, {o_busy, o_conv_req})
  endtask : t_reset_values

  task automatic t_pairs;
    host.send2(16'h6E80);
    host.send2(16'h6FC0);
    host.send1(8'h98);
    tick(1);
    `CHK("source", 2'h3, o_voltage_source)
    expect_sweep('{7'h20, 7'h32});
  endtask : t_pairs

  task automatic t_reset_temp;
    host.send1(8'h10);
    tick(1);
    `CHK("timing mode", 2'h2, o_timing_mode)
    `CHK("source", 2'h0, o_voltage_source)
    host.send1(8'hE3);
    expect_sweep('{7'h40, 7'h0C, 7'h0D, 7'h0F});
    `CHK("sweep time", 24'h00038E, o_sweep_cycles)
  endtask : t_reset_temp

  task automatic t_ignore_fresh;
    host.send1(8'h05);
    tick(1);
    `CHK("source", 2'h0, o_voltage_source)
    `CHK("busy", 1'b0, o_busy)
    host.send2(16'h6DA6);
    expect_sweep('{7'h04});
    `CHK("source", 2'h3, o_voltage_source)
  endtask : t_ignore_fresh

  task automatic t_repeat_avg;
    host.send1(8'h3C);
    tick(1);
    `CHK("samples", 6'h20, o_samples_per_result)
    host.send1(8'h94);
    expect_sweep('{7'h02, 7'h02, 7'h02, 7'h02});
    `CHK("sweep time", 24'h000A00, o_sweep_cycles)
  endtask : t_repeat_avg

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      host.send1({2'h1, m[1:0], 4'hC});
      tick(1);
      `CHK("timing mode", m[1:0], o_timing_mode)
      `CHK("samples", (m == 3) ? 6'h01 : 6'h20, o_samples_per_result)
      if (m[0]) `CHK("untimed sweep time", 24'h000000, o_sweep_cycles)
    end
    host.send1(8'h2C);
    tick(1);
    `CHK("samples", 6'h01, o_samples_per_result)
  endtask : t_modes

  task automatic t_pin_start;
    host.send1(8'h4C);
    host.send1(8'hEA);
    tick(4);
    `CHK("no start on write", 2'h0, {o_busy, o_conv_req})
    i_conv_start_n = 1'b0;
    tick(3);
    i_conv_start_n = 1'b1;
    expect_sweep('{7'h0D, 7'h0E});
    host.send1(8'h6C);
  endtask : t_pin_start

  task automatic t_fifo_clear;
    int w;
    logic seen;
    seen = 1'b0;
    fork
      host.send1(8'h18);
      for (w = 0; w < 30 && !seen; w++) begin tick(1); seen = (o_fifo_clear === 1'b1); end
    join
    `CHK("fifo clear", 1'b1, seen)
    `CHK("source kept", 2'h3, o_voltage_source)
  endtask : t_fifo_clear

  initial begin
    i_reset = 1'b1;
    i_conv_start_n = 1'b1;
    i_conv_done = 1'b0;
    tick(16);
    i_reset = 1'b0;
    tick(4);
    t_reset_values();
    t_pairs();
    t_reset_temp();
    t_ignore_fresh();
    t_repeat_avg();
    t_modes();
    t_pin_start();
    t_fifo_clear();
    close_out();
  end
endmodule : tb_adc_command_register_decoder
